// ### common/itte_cfg.svh
/*
 * Constants of the interrupt triggered transfer engine: register offsets,
 * field positions, reset values and limits.
 * Assumes inclusion by bare name from the engine.
 */
`ifndef ITTE_CFG_SVH
`define ITTE_CFG_SVH

// counts of sources, channels and enable registers
`define ITTE_NUM_SRC 40
`define ITTE_NUM_CH 24
`define ITTE_NUM_EN_REG 4
`define ITTE_EN_BITS 32

// register map, byte addresses
`define ITTE_OFS_EN0 12'h000
`define ITTE_OFS_STATUS 12'h010
`define ITTE_OFS_CH_BASE 12'h100
`define ITTE_CH_STRIDE_LOG2 5
`define ITTE_FLD_CTRL 3'h0
`define ITTE_FLD_COUNT 3'h1
`define ITTE_FLD_RELOAD 3'h2
`define ITTE_FLD_SRC 3'h3
`define ITTE_FLD_DST 3'h4

// channel control field positions
`define ITTE_CC_WORD 0
`define ITTE_CC_REPEAT 1
`define ITTE_CC_RPT_IRQ 2
`define ITTE_CC_SRC_INC 3
`define ITTE_CC_DST_INC 4
`define ITTE_CC_RPT_DST 5
`define ITTE_CC_SEL_LSB 8
`define ITTE_CC_SEL_MSB 13

// status field positions
`define ITTE_ST_BUSY 0
`define ITTE_ST_ERR 1
`define ITTE_ST_CH_LSB 8

// reset values
`define ITTE_CTRL_RST 16'h0000
`define ITTE_COUNT_RST 8'h00
`define ITTE_ADDR_RST 16'h0000

// transfer window and limits
`define ITTE_WIN_TOP 4'hf
`define ITTE_REPEAT_MAX 8'hff

// address ranges barred from transfers, the mirror range as destination only
`define ITTE_GPR_LO 16'hfee0
`define ITTE_GPR_HI 16'hfeff
`define ITTE_MIRROR_LO 16'h0000
`define ITTE_MIRROR_HI 16'hefff

`endif

// ### common/itte_pkg.sv
/*
 * Types of the interrupt triggered transfer engine.
 * Assumes itte_cfg.svh holds the numeric constants.
 */
package itte_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE,
      ST_UPDATE
   } itte_state_e;
   typedef logic [4:0] itte_chan_t;
endpackage

// ### logic/itte_transfer_engine.sv
/*
 * Interrupt triggered transfer engine: AHB-Lite register slave, channel
 * control data, activation logic and the bus master that moves the data.
 * Assumes a system bus that ends each access with memAck, CPU instruction flags
 * synchronous to sys_clk, and one-cycle activation source pulses.
 */
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
// Contract
// - a peripheral interrupt starts the engine, which moves data without CPU
// - engine and CPU share one bus; the engine wins when both want it
// - forty activation sources and twenty-four sets of control data
// - addresses lie in F0000H..FFFFFH, general-purpose registers excluded
// - mirror area may be read from but never written to
// - at most 256 transfers in normal mode, 255 in repeat mode
// - block per activation at most 256/512 bytes normal, 255 repeat; the code moves one byte or word per activation
// - each channel moves either bytes or 16-bit words
// - normal mode ends after the transfer taking the count from 1 to 0
// - repeat mode at 1 to 0 restores repeat address, reloads count
// - addresses fixed or incremented; repeat area follows its own rule
// - normal mode at 1 to 0 forwards the source interrupt after transfer
// - repeat mode forwards the interrupt only with repeat_irq_enable set
// - each source occurrence with enable bit set starts one transfer
// - transfers stop on enable cleared, or count zero as rules state
// - requests are deferred right after pending-type CPU instructions
// - never start between segment_opcode_a and the next instruction
// - accepted transfer holds all CPU interrupts until it completes
// - while deferred by a pending instruction, CPU interrupts held
// - four activation enable registers of eight bits, channels 0..23
`timescale 1ns/100ps
`include "itte_cfg.svh"

module itte_transfer_engine (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [39:0] srcIrq,
   input wire logic cpuDeferInstr,
   input wire logic cpuPrefixGap,
   input wire logic cpuBusReq,
   output logic cpuBusGrant,
   output logic memReq,
   output logic memWrite,
   output logic memWord,
   output logic [19:0] memAddr,
   output logic [15:0] memWdata,
   input wire logic [15:0] memRdata,
   input wire logic memAck,
   output logic [39:0] irqFwd,
   output logic cpuIrqHold,
   output logic engineBusy
);

   // true when the byte address falls in the channel block
   function automatic logic isChan(input logic [11:0] a);
      logic [4:0] idx;
      idx = a[9:5] - 5'd8;
      isChan = (a[11:10] == 2'b00) && (a[9:8] != 2'b00) &&
               (idx < 5'd24) && (a[4:2] <= `ITTE_FLD_DST);
   endfunction

   function automatic logic [4:0] chOf(input logic [11:0] a);
      chOf = a[9:5] - 5'd8;
   endfunction

   // address barred for this direction
   function automatic logic badAddr(input logic [15:0] a, input logic dst);
      badAddr = (a >= `ITTE_GPR_LO && a <= `ITTE_GPR_HI) ||
                (dst && a <= `ITTE_MIRROR_HI && a >= `ITTE_MIRROR_LO);
   endfunction

   // channel storage
   logic [15:0] ctrl_q [0:23];
   logic [7:0] count_q [0:23];
   logic [7:0] reload_q [0:23];
   logic [15:0] srcAddr_q [0:23];
   logic [15:0] dstAddr_q [0:23];
   logic [15:0] srcInit_q [0:23];
   logic [15:0] dstInit_q [0:23];
   logic [31:0] enable_q;
   logic [23:0] chanPend_q;
   logic errFlag_q;

   // bus slave state
   logic wrEn_q;
   logic [11:0] wrAddr_q;
   logic rdPend_q;
   logic [11:0] rdAddr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;

   // engine state
   itte_pkg::itte_state_e state_q;
   itte_pkg::itte_chan_t cur_q;
   logic [15:0] data_q;
   logic skip_q;
   logic memReq_q;
   logic memWrite_q;
   logic memWord_q;
   logic [19:0] memAddr_q;
   logic [15:0] memWdata_q;
   logic [39:0] irqFwd_q;
   logic cpuIrqHold_q;
   logic cpuBusGrant_q;
   logic engineBusy_q;

   // combinational helpers
   logic addrPhase;
   logic canStart;
   logic accept;
   logic [4:0] pick;
   logic [23:0] trig;
   logic [15:0] curCtrl;
   logic lastXfer;
   logic stopNow;
   logic [15:0] step;
   logic swWrChan;
   logic [4:0] swCh;
   logic [2:0] swFld;

   assign addrPhase = hsel && htrans[1] && hready;
   assign swWrChan = wrEn_q && isChan(wrAddr_q);
   assign swCh = chOf(wrAddr_q);
   assign swFld = wrAddr_q[4:2];
   assign curCtrl = ctrl_q[cur_q];
   assign step = curCtrl[`ITTE_CC_WORD] ? 16'h0002 : 16'h0001;
   assign lastXfer = (count_q[cur_q] == 8'h01);
   // stop condition and interrupt forwarding share one term
   assign stopNow = lastXfer && (!curCtrl[`ITTE_CC_REPEAT] ||
                                 curCtrl[`ITTE_CC_RPT_IRQ]);

   // one source pulse arms every enabled channel bound to it
   always_comb begin
      for (int j = 0; j < 24; j++) begin
         trig[j] = enable_q[j] &&
            srcIrq[ctrl_q[j][`ITTE_CC_SEL_MSB:`ITTE_CC_SEL_LSB]];
      end
   end

   // lowest pending channel wins
   always_comb begin
      pick = 5'd0;
      for (int j = 23; j >= 0; j--) begin
         if (chanPend_q[j]) begin
            pick = j[4:0];
         end
      end
   end

   // start allowed only outside deferral windows
   assign canStart = !cpuDeferInstr && !cpuPrefixGap;
   assign accept = (state_q == itte_pkg::ST_IDLE) && (|chanPend_q) &&
                   canStart;

   // bus slave: address phase capture, one wait state on reads
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wrEn_q <= 1'b0;
         wrAddr_q <= 12'h000;
         rdPend_q <= 1'b0;
         rdAddr_q <= 12'h000;
         hreadyout_q <= 1'b1;
      end else begin
         wrEn_q <= addrPhase && hwrite && (hsize == 3'h2);
         rdPend_q <= addrPhase && !hwrite;
         hreadyout_q <= !(addrPhase && !hwrite);
         if (addrPhase) begin
            wrAddr_q <= haddr[11:0];
            rdAddr_q <= haddr[11:0];
         end
      end
   end

   // read data, unmapped reads as zero
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rdPend_q) begin
         hrdata_q <= 32'h0000_0000;
         if (rdAddr_q[11:4] == 8'h00) begin
            hrdata_q <= {24'h00_0000, enable_q[rdAddr_q[3:2]*8 +: 8]};
         end else if (rdAddr_q == `ITTE_OFS_STATUS) begin
            hrdata_q <= {19'h0_0000, cur_q, 6'h00, errFlag_q,
                         state_q != itte_pkg::ST_IDLE};
         end else if (isChan(rdAddr_q)) begin
            case (rdAddr_q[4:2])
               `ITTE_FLD_CTRL: hrdata_q <= {16'h0000, ctrl_q[chOf(rdAddr_q)]};
               `ITTE_FLD_COUNT: hrdata_q <= {24'h00_0000,
                                             count_q[chOf(rdAddr_q)]};
               `ITTE_FLD_RELOAD: hrdata_q <= {24'h00_0000,
                                              reload_q[chOf(rdAddr_q)]};
               `ITTE_FLD_SRC: hrdata_q <= {16'h0000,
                                           srcAddr_q[chOf(rdAddr_q)]};
               `ITTE_FLD_DST: hrdata_q <= {16'h0000,
                                           dstAddr_q[chOf(rdAddr_q)]};
               default: hrdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // enable bits: software writes, engine clears at the end of a run
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         enable_q <= 32'h0000_0000;
      end else begin
         if (state_q == itte_pkg::ST_UPDATE && stopNow) begin
            enable_q[cur_q] <= 1'b0;
         end
         if (wrEn_q && wrAddr_q[11:4] == 8'h00) begin
            enable_q[wrAddr_q[3:2]*8 +: 8] <= hwdata[7:0];
         end
      end
   end

   // pending per channel, a new trigger wins over the acceptance clear
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         chanPend_q <= 24'h00_0000;
      end else begin
         for (int j = 0; j < 24; j++) begin
            if (trig[j]) begin
               chanPend_q[j] <= 1'b1;
            end else if ((accept && pick == j[4:0]) || !enable_q[j]) begin
               chanPend_q[j] <= 1'b0;
            end
         end
      end
   end

   // sticky barred-address flag, write one to clear, set wins
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         errFlag_q <= 1'b0;
      end else if (state_q == itte_pkg::ST_UPDATE && skip_q) begin
         errFlag_q <= 1'b1;
      end else if (wrEn_q && wrAddr_q == `ITTE_OFS_STATUS &&
                   hwdata[`ITTE_ST_ERR]) begin
         errFlag_q <= 1'b0;
      end
   end

   // channel control words and reload values, software only
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int j = 0; j < 24; j++) begin
            ctrl_q[j] <= `ITTE_CTRL_RST;
            reload_q[j] <= `ITTE_COUNT_RST;
            srcInit_q[j] <= `ITTE_ADDR_RST;
            dstInit_q[j] <= `ITTE_ADDR_RST;
         end
      end else if (swWrChan) begin
         case (swFld)
            `ITTE_FLD_CTRL: ctrl_q[swCh] <= hwdata[15:0];
            `ITTE_FLD_RELOAD: reload_q[swCh] <= hwdata[7:0];
            `ITTE_FLD_SRC: srcInit_q[swCh] <= hwdata[15:0];
            `ITTE_FLD_DST: dstInit_q[swCh] <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // transfer count: 0 stands for 256, reload capped for repeat mode
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int j = 0; j < 24; j++) begin
            count_q[j] <= `ITTE_COUNT_RST;
         end
      end else begin
         if (state_q == itte_pkg::ST_UPDATE) begin
            if (lastXfer && curCtrl[`ITTE_CC_REPEAT]) begin
               count_q[cur_q] <= (reload_q[cur_q] == 8'h00) ?
                  `ITTE_REPEAT_MAX : reload_q[cur_q];
            end else begin
               count_q[cur_q] <= count_q[cur_q] - 8'h01;
            end
         end
         if (swWrChan && swFld == `ITTE_FLD_COUNT) begin
            count_q[swCh] <= hwdata[7:0];
         end
      end
   end

   // working addresses: increment, hold, or restore the repeat area
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int j = 0; j < 24; j++) begin
            srcAddr_q[j] <= `ITTE_ADDR_RST;
            dstAddr_q[j] <= `ITTE_ADDR_RST;
         end
      end else begin
         if (state_q == itte_pkg::ST_UPDATE) begin
            if (curCtrl[`ITTE_CC_REPEAT] && lastXfer &&
                !curCtrl[`ITTE_CC_RPT_DST]) begin
               srcAddr_q[cur_q] <= srcInit_q[cur_q];
            end else if (curCtrl[`ITTE_CC_SRC_INC]) begin
               srcAddr_q[cur_q] <= srcAddr_q[cur_q] + step;
            end
            if (curCtrl[`ITTE_CC_REPEAT] && lastXfer &&
                curCtrl[`ITTE_CC_RPT_DST]) begin
               dstAddr_q[cur_q] <= dstInit_q[cur_q];
            end else if (curCtrl[`ITTE_CC_DST_INC]) begin
               dstAddr_q[cur_q] <= dstAddr_q[cur_q] + step;
            end
         end
         if (swWrChan && swFld == `ITTE_FLD_SRC) begin
            srcAddr_q[swCh] <= hwdata[15:0];
         end
         if (swWrChan && swFld == `ITTE_FLD_DST) begin
            dstAddr_q[swCh] <= hwdata[15:0];
         end
      end
   end

   // transfer sequencer and system bus master
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= itte_pkg::ST_IDLE;
         cur_q <= 5'd0;
         data_q <= 16'h0000;
         skip_q <= 1'b0;
         memReq_q <= 1'b0;
         memWrite_q <= 1'b0;
         memWord_q <= 1'b0;
         memAddr_q <= 20'h0_0000;
         memWdata_q <= 16'h0000;
      end else begin
         case (state_q)
            itte_pkg::ST_IDLE: begin
               if (accept) begin
                  cur_q <= pick;
                  memWord_q <= ctrl_q[pick][`ITTE_CC_WORD];
                  memAddr_q <= {`ITTE_WIN_TOP, srcAddr_q[pick]};
                  memWrite_q <= 1'b0;
                  if (badAddr(srcAddr_q[pick], 1'b0) ||
                      badAddr(dstAddr_q[pick], 1'b1)) begin
                     skip_q <= 1'b1;
                     state_q <= itte_pkg::ST_UPDATE;
                  end else begin
                     skip_q <= 1'b0;
                     memReq_q <= 1'b1;
                     state_q <= itte_pkg::ST_READ;
                  end
               end
            end
            itte_pkg::ST_READ: begin
               if (memAck) begin
                  data_q <= memRdata;
                  memWdata_q <= memRdata;
                  memWrite_q <= 1'b1;
                  memAddr_q <= {`ITTE_WIN_TOP, dstAddr_q[cur_q]};
                  state_q <= itte_pkg::ST_WRITE;
               end
            end
            itte_pkg::ST_WRITE: begin
               if (memAck) begin
                  memReq_q <= 1'b0;
                  memWrite_q <= 1'b0;
                  state_q <= itte_pkg::ST_UPDATE;
               end
            end
            itte_pkg::ST_UPDATE: begin
               state_q <= itte_pkg::ST_IDLE;
            end
            default: begin
               state_q <= itte_pkg::ST_IDLE;
               memReq_q <= 1'b0;
            end
         endcase
      end
   end

   // completion interrupt to the CPU once the last transfer is done
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irqFwd_q <= 40'h00_0000_0000;
      end else begin
         irqFwd_q <= 40'h00_0000_0000;
         if (state_q == itte_pkg::ST_UPDATE && stopNow) begin
            irqFwd_q[curCtrl[`ITTE_CC_SEL_MSB:`ITTE_CC_SEL_LSB]] <=
               1'b1;
         end
      end
   end

   // CPU interrupt hold and bus grant, engine has priority
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cpuIrqHold_q <= 1'b0;
         cpuBusGrant_q <= 1'b0;
         engineBusy_q <= 1'b0;
      end else begin
         // busy flop mirrors the next sequencer state
         engineBusy_q <= (state_q == itte_pkg::ST_IDLE && accept) ||
            state_q == itte_pkg::ST_READ || state_q == itte_pkg::ST_WRITE;
         cpuIrqHold_q <= accept ||
            (state_q != itte_pkg::ST_IDLE &&
             state_q != itte_pkg::ST_UPDATE) ||
            ((|chanPend_q) && !canStart);
         cpuBusGrant_q <= cpuBusReq && !accept &&
            state_q == itte_pkg::ST_IDLE;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = 1'b0;
   assign cpuBusGrant = cpuBusGrant_q;
   assign memReq = memReq_q;
   assign memWrite = memWrite_q;
   assign memWord = memWord_q;
   assign memAddr = memAddr_q;
   assign memWdata = memWdata_q;
   assign irqFwd = irqFwd_q;
   assign cpuIrqHold = cpuIrqHold_q;
   assign engineBusy = engineBusy_q;

endmodule // itte_transfer_engine

// ### testbench/itte_checker.sv
/*
 * Concurrent checks on the ports of the transfer engine.
 * Assumes one clock domain and binding to itte_transfer_engine.
 */
`timescale 1ns/100ps
module itte_checker (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cpuDeferInstr,
   input wire logic cpuPrefixGap,
   input wire logic cpuBusGrant,
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic memWord,
   input wire logic [19:0] memAddr,
   input wire logic memAck,
   input wire logic [39:0] irqFwd,
   input wire logic cpuIrqHold,
   input wire logic engineBusy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   // bus ownership and address window
   property p_grant; memReq |-> !cpuBusGrant; endproperty
   a_grant: assert property (p_grant) else $error("grant in transfer");
   property p_win; memReq |-> memAddr[19:16] == 4'hf; endproperty
   a_win: assert property (p_win) else $error("address off window");
   property p_gpr; memReq |-> !(memAddr[15:0] inside {[16'hfee0:16'hfeff]});
   endproperty
   a_gpr: assert property (p_gpr) else $error("register area used");
   property p_mir; memReq && memWrite |-> memAddr[15:0] > 16'hefff; endproperty
   a_mir: assert property (p_mir) else $error("mirror written");

   // start deferral, interrupt holding and forwarding
   property p_defer;
      (cpuDeferInstr || cpuPrefixGap) && !engineBusy |=> !engineBusy;
   endproperty
   a_defer: assert property (p_defer) else $error("start not deferred");
   property p_hold; memReq |-> cpuIrqHold; endproperty
   a_hold: assert property (p_hold) else $error("irq not held");
   property p_tail;
      memReq && memWrite && memAck |=> !memReq && cpuIrqHold;
   endproperty
   a_tail: assert property (p_tail) else $error("bad end of unit");
   property p_fwd;
      irqFwd != 40'h0 |-> $onehot(irqFwd) && $past(memAck && memWrite, 2);
   endproperty
   a_fwd: assert property (p_fwd) else $error("irq forward misplaced");

   // main scenarios
   c_fwd: cover property (irqFwd != 40'h0);
   c_word: cover property (memAck && memWrite && memWord);
   c_defer: cover property (cpuDeferInstr && !engineBusy ##1 cpuIrqHold);
   c_grant: cover property (cpuBusGrant);
endmodule // itte_checker

bind itte_transfer_engine itte_checker u_chk (.sys_clk, .reset,
   .cpuDeferInstr, .cpuPrefixGap, .cpuBusGrant, .memReq, .memWrite,
   .memWord, .memAddr, .memAck, .irqFwd, .cpuIrqHold, .engineBusy);

// ### testbench/itte_mem_model.sv
/*
 * System bus memory standing opposite the engine: acks after lat cycles.
 * Assumes memReq is held until memAck; read data is a pattern of address.
 */
`timescale 1ns/100ps
module itte_mem_model #(
   parameter logic [15:0] PAT = 16'h5a3c
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [19:0] memAddr,
   input wire logic [1:0] lat,
   output logic memAck,
   output logic [15:0] memRdata
);
   logic [1:0] waitCnt_q;

   // one ack per access; data changes every cycle off the ack
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         memAck <= 1'b0;
         waitCnt_q <= 2'h0;
         memRdata <= 16'h0;
      end else begin
         memAck <= 1'b0;
         memRdata <= ~memRdata;
         if (memReq && !memAck) begin
            if (waitCnt_q >= lat) begin
               memAck <= 1'b1;
               waitCnt_q <= 2'h0;
               if (!memWrite) memRdata <= memAddr[15:0] ^ PAT;
            end else begin
               waitCnt_q <= waitCnt_q + 2'h1;
            end
         end
      end
   end
endmodule // itte_mem_model

// ### testbench/interrupt_triggered_transfer_engine_tb_top.sv
/*
 * Self-checking bench of the transfer engine over AHB-Lite.
 * Assumes the memory model answers the engine and the checker is bound.
 */
`timescale 1ns/100ps
module interrupt_triggered_transfer_engine_tb_top;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [39:0] srcIrq = 40'h0;
   logic cpuDeferInstr = 1'b0;
   logic cpuPrefixGap = 1'b0;
   logic cpuBusReq = 1'b0;
   logic [1:0] lat = 2'h0;
   logic rdPhase = 1'b0;
   logic hreadyout, hresp, cpuBusGrant, memReq, memWrite, memWord, memAck;
   logic cpuIrqHold, engineBusy;
   logic [31:0] hrdata;
   logic [39:0] irqFwd;
   logic [19:0] memAddr;
   logic [15:0] memWdata, memRdata;
   logic [63:0] rdQ[$];
   logic [36:0] memQ[$];
   logic [39:0] irqQ[$];
   logic [63:0] rdNote;
   logic [36:0] wrNote;
   int failures = 0;
   int checked = 0;
   localparam logic [15:0] PAT = 16'h5a3c;

   always #50 sys_clk = ~sys_clk;

   itte_transfer_engine uut (.sys_clk, .reset, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
      .hresp, .srcIrq, .cpuDeferInstr, .cpuPrefixGap, .cpuBusReq,
      .cpuBusGrant, .memReq, .memWrite, .memWord, .memAddr, .memWdata,
      .memRdata, .memAck, .irqFwd, .cpuIrqHold, .engineBusy);
   itte_mem_model #(.PAT(PAT)) u_mem (.sys_clk, .reset, .memReq, .memWrite,
      .memAddr, .lat, .memAck, .memRdata);

   task automatic end_of_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [39:0] exp, got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic waitRdy;
      for (int i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (hreadyout === 1'b1) return;
      end
      chk("hready wait", 40'h1, 40'h0);
      end_of_test;
   endtask

   // one single AHB transfer; a read notes its expected masked word
   task automatic ahb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, m);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdPhase <= !wr;
      if (!wr) rdQ.push_back({m, d & m});
      waitRdy;
      rdPhase <= 1'b0;
   endtask

   task automatic cfg(input int ch, input logic [15:0] c,
                      input logic [7:0] n, r, input logic [15:0] s, d);
      logic [11:0] b;
      b = 12'h100 + 12'(ch * 32);
      ahb(1'b1, b, {16'h0, c}, 32'h0);
      ahb(1'b1, b + 12'h4, {24'h0, n}, 32'h0);
      ahb(1'b1, b + 12'h8, {24'h0, r}, 32'h0);
      ahb(1'b1, b + 12'hc, {16'h0, s}, 32'h0);
      ahb(1'b1, b + 12'h10, {16'h0, d}, 32'h0);
   endtask

   task automatic trig(input logic [39:0] m);
      @(posedge sys_clk);
      srcIrq <= m;
      @(posedge sys_clk);
      srcIrq <= 40'h0;
   endtask

   task automatic drain;
      for (int i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (memQ.size() == 0 && irqQ.size() == 0 && engineBusy === 1'b0)
            return;
      end
      chk("transfer wait", 40'h1, 40'h0);
      end_of_test;
   endtask

   function automatic logic [36:0] note(input logic w,
                                        input logic [15:0] s, d);
      return {w, 4'hf, d, (s ^ PAT) & (w ? 16'hffff : 16'h00ff)};
   endfunction

   // random bus contention and memory latency
   always @(posedge sys_clk) begin
      cpuBusReq <= 1'($urandom);
      lat <= 2'($urandom % 3);
   end

   // oldest note against each result on the ports
   always @(posedge sys_clk) begin
      if (rdPhase && hreadyout === 1'b1) begin
         rdNote = rdQ.size() ? rdQ.pop_front() : 'x;
         chk("hrdata", {8'h0, rdNote[31:0]},
             {7'h0, hresp, hrdata & rdNote[63:32]});
      end
      if (memReq && memWrite && memAck === 1'b1) begin
         wrNote = memQ.size() ? memQ.pop_front() : 'x;
         chk("write", {3'h0, wrNote}, {3'h0, memWord, memAddr,
            memWdata & (memWord ? 16'hffff : 16'h00ff)});
      end
      if (irqFwd !== 40'h0)
         chk("irqFwd", irqQ.size() ? irqQ.pop_front() : 'x, irqFwd);
   end

   initial begin
      int s;
      void'($urandom(32'hd434aae0));
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      // reset value, unmapped place, last channel
      ahb(1'b0, 12'h1a0, 32'h0, 32'hffffffff);
      ahb(1'b0, 12'h800, 32'h0, 32'hffffffff);
      ahb(1'b1, 12'h3e4, 32'h80, 32'h0);
      ahb(1'b0, 12'h3e4, 32'h80, 32'hff);
      // normal byte mode from the mirror, random source
      s = $urandom % 40;
      cfg(1, 16'(s << 8) | 16'h0018, 8'h2, 8'h0, 16'h1000, 16'hf200);
      ahb(1'b1, 12'h000, 32'h2, 32'h0);
      for (int k = 0; k < 2; k++) begin
         memQ.push_back(note(1'b0, 16'h1000 + 16'(k), 16'hf200 + 16'(k)));
         if (k == 1) irqQ.push_back(40'h1 << s);
         trig(40'h1 << s);
         drain;
      end
      ahb(1'b0, 12'h000, 32'h0, 32'hff);
      ahb(1'b0, 12'h124, 32'h0, 32'hff);
      trig(40'h1 << s);
      drain;
      // repeat word mode, repeat area on the source, then on the destination
      cfg(3, 16'h091b, 8'h2, 8'h2, 16'hf300, 16'hf400);
      ahb(1'b1, 12'h000, 32'h8, 32'h0);
      for (int k = 0; k < 3; k++) begin
         memQ.push_back(note(1'b1, 16'hf300 + 16'(2 * (k % 2)),
            16'hf400 + 16'(2 * k)));
         trig(40'h200);
         drain;
      end
      ahb(1'b0, 12'h000, 32'h8, 32'hff);
      ahb(1'b0, 12'h164, 32'h1, 32'hff);
      ahb(1'b1, 12'h164, 32'h1, 32'h0);
      ahb(1'b1, 12'h160, 32'h093f, 32'h0);
      memQ.push_back(note(1'b1, 16'hf302, 16'hf406));
      irqQ.push_back(40'h200);
      trig(40'h200);
      drain;
      ahb(1'b0, 12'h000, 32'h0, 32'hff);
      ahb(1'b0, 12'h16c, 32'hf304, 32'hffff);
      ahb(1'b0, 12'h170, 32'hf400, 32'hffff);
      // two sources at once: lower channel first
      cfg(2, 16'h1400, 8'h4, 8'h0, 16'hf500, 16'hf600);
      cfg(4, 16'h1500, 8'h4, 8'h0, 16'hf510, 16'hf610);
      ahb(1'b1, 12'h000, 32'h14, 32'h0);
      memQ.push_back(note(1'b0, 16'hf500, 16'hf600));
      memQ.push_back(note(1'b0, 16'hf510, 16'hf610));
      trig(40'h300000);
      drain;
      // start held off by each CPU condition
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk);
         cpuDeferInstr <= (k == 0);
         cpuPrefixGap <= (k == 1);
         trig(40'h100000);
         repeat (3) begin
            @(posedge sys_clk);
            chk("engineBusy", 40'h0, {39'h0, engineBusy});
         end
         chk("cpuIrqHold", 40'h1, {39'h0, cpuIrqHold});
         memQ.push_back(note(1'b0, 16'hf500, 16'hf600));
         cpuDeferInstr <= 1'b0;
         cpuPrefixGap <= 1'b0;
         drain;
      end
      // refused destinations flag an error, cleared by writing one
      for (int k = 0; k < 2; k++) begin
         ahb(1'b1, 12'h190, k ? 32'h2000 : 32'hfef0, 32'h0);
         trig(40'h200000);
         for (int i = 0; i < 20 && engineBusy !== 1'b1; i++)
            @(posedge sys_clk);
         chk("engineBusy", 40'h1, {39'h0, engineBusy});
         drain;
         ahb(1'b0, 12'h010, 32'h2, 32'h3);
         ahb(1'b1, 12'h010, 32'h2, 32'h0);
         ahb(1'b0, 12'h010, 32'h0, 32'h3);
      end
      chk("notes left", 40'h0, 40'(memQ.size() + irqQ.size()));
      end_of_test;
   end
endmodule // interrupt_triggered_transfer_engine_tb_top
